// ### src/lerc_pkg.sv
// Constants, register map and carrier types of the link error reporting block.
// Assumes one 25 MHz clock and an 8-bit register port.
package lerc_pkg;

   // ***********************************************
   // Register addresses
   // ***********************************************
   localparam logic [7:0] ADDR_WAKE_CONTROL       = 8'h0c;
   localparam logic [7:0] ADDR_RESET_SLEEP        = 8'h10;
   localparam logic [7:0] ADDR_CABLE_REFERENCE    = 8'h11;
   localparam logic [7:0] ADDR_REGULATOR_BYPASS   = 8'h12;
   localparam logic [7:0] ADDR_LOCK_ERROR_STATUS  = 8'h13;
   localparam logic [7:0] ADDR_ERROR_THRESHOLD    = 8'h18;
   localparam logic [7:0] ADDR_PACKET_COUNT_CFG   = 8'h19;
   localparam logic [7:0] ADDR_LINK_REPORT_EN     = 8'h1a;
   localparam logic [7:0] ADDR_LINK_FLAGS         = 8'h1b;
   localparam logic [7:0] ADDR_SUPPLY_REPORT_EN   = 8'h1c;
   localparam logic [7:0] ADDR_SUPPLY_FLAGS       = 8'h1d;
   localparam logic [7:0] ADDR_POWER_REPORT_EN    = 8'h1e;
   localparam logic [7:0] ADDR_DECODE_COUNT       = 8'h22;
   localparam logic [7:0] ADDR_IDLE_COUNT         = 8'h24;
   localparam logic [7:0] ADDR_PACKET_COUNT       = 8'h25;
   localparam logic [7:0] ADDR_PACKET_THRESHOLD   = 8'h30;

   // ***********************************************
   // Reset values and writable masks
   // ***********************************************
   localparam logic [7:0] RST_WAKE      = 8'h15;
   localparam logic [7:0] MSK_WAKE      = 8'h50;
   localparam logic [7:0] RST_RESET_SLEEP_CONTROL_RO  = 8'h01;
   localparam logic [7:0] RST_CABLE     = 8'h02;
   localparam logic [7:0] MSK_CABLE     = 8'h41;
   localparam logic [7:0] RST_REGBYP    = 8'h04;
   localparam logic [7:0] MSK_REGBYP    = 8'h10;
   localparam logic [7:0] RST_STAT_RO   = 8'h10;
   localparam logic [7:0] RST_THR       = 8'ha0;
   localparam logic [7:0] MSK_THR       = 8'h0f;
   localparam logic [7:0] RST_PCFG      = 8'h00;
   localparam logic [7:0] MSK_PCFG      = 8'hf8;
   localparam logic [7:0] RST_LREN      = 8'h09;
   localparam logic [7:0] MSK_LREN      = 8'had;
   localparam logic [7:0] RST_SREN      = 8'h08;
   localparam logic [7:0] MSK_SREN      = 8'hfe;
   localparam logic [7:0] RST_PREN      = 8'hfb;
   localparam logic [7:0] MSK_PREN      = 8'hfd;
   localparam logic [7:0] RST_PTHR      = 8'hff;
   localparam logic [7:0] CNT_MAX       = 8'hff;

   // ***********************************************
   // Field positions
   // ***********************************************
   localparam int BIT_LOCAL_WAKE_DIS = 6;
   localparam int BIT_REMOTE_WAKE_EN = 4;
   localparam int BIT_CHIP_RESET     = 7;
   localparam int BIT_LINK_RESET     = 6;
   localparam int BIT_RESET_PULSE    = 5;
   localparam int BIT_SLEEP          = 3;
   localparam int BIT_ERR_STATUS     = 2;
   localparam int BIT_ERR_AUTOCLR    = 3;
   localparam int BIT_PKT_AUTOCLR    = 3;
   localparam int THR_MSB            = 2;

   // ***********************************************
   // Timing
   // ***********************************************
   localparam int CLK_PERIOD_NS  = 40;
   localparam int ERR_HOLD_NS    = 1000;
   localparam int HOLD_W         = 5;
   localparam logic [HOLD_W-1:0] HOLD_CYC =
      HOLD_W'((ERR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // ***********************************************
   // Carriers
   // ***********************************************
   typedef struct packed {
      logic refclk_unlock;
      logic remote_err_n;
      logic line_fault0;
      logic line_fault1;
      logic core_ov;
      logic eye_low;
      logic dig_ov;
      logic io18_ov;
      logic retx_limit;
      logic retx_event;
      logic link_locked;
      logic clock_multiplier_lock;
      logic local_wake;
      logic remote_wake;
   } lerc_mon_t;

   typedef struct packed {
      logic decode_err;
      logic idle_err;
      logic packet;
   } lerc_evt_t;

endpackage

// ### src/lerc_top.sv
// Control, status and error pin logic of a serializer's link error reporting.
// Assumes monitor levels arrive asynchronously and counter events on sys_clk_i.
//
// Behaviour
// RQ1: Chip reset bit restores all defaults, self-clears
// RQ2: Level data-path reset follows its bit
// RQ3: Pulse data-path reset bit self-clears, releases
// RQ4: Sleep follows the sleep control bit
// RQ5: Local wake ignored when disable bit set
// RQ6: Remote wake accepted only when enabled
// RQ7: Status shows link lock
// RQ8: Status error bit mirrors low error pin
// RQ9: Status shows clock multiplier lock
// RQ10: Auto-clear error counters after 1us error
// RQ11: Auto-clear packet counter after 1us error
// RQ12: Threshold equals two to field value
// RQ13: Idle flag when idle count reaches threshold
// RQ14: Decode flag when decode count reaches threshold
// RQ15: Each enable gates its flag to pin
// RQ16: Reference clock unlock flag is live
// RQ17: Remote error flag inverts remote pin
// RQ18: Line fault flag from either monitor
// RQ19: Overvoltage flags sticky, cleared by read
// RQ20: Eye-opening flag sticky, cleared by read
// RQ21: Retransmission limit and event flags combined
// RQ22: Packet flag when count reaches threshold
// RQ23: Decode counter clears on read, lock
// RQ24: Idle counter clears on read, lock
// RQ25: Error pin low when any enabled flag
// RQ26: Read-only flags live, not read-cleared
//
// Added by the designer: strobed register access.
`timescale 1ns/1ns

module lerc_top (
   // Clock, reset, enable
   input  wire logic              sys_clk_i,
   input  wire logic              rst_n_i,
   input  wire logic              ce_i,
   // Register port
   input  wire logic [7:0]        addr_i,
   input  wire logic [7:0]        wdata_i,
   input  wire logic              wr_i,
   input  wire logic              rd_i,
   output logic      [7:0]        rdata_o,
   // Monitors and events
   input  wire lerc_pkg::lerc_mon_t mon_i,
   input  wire lerc_pkg::lerc_evt_t evt_i,
   // Control outputs
   output logic                   error_pin_n_o,
   output logic                   chip_reset_o,
   output logic                   datapath_reset_o,
   output logic                   sleep_o,
   output logic                   wake_o
);

   // ***********************************************
   // Declarations
   // ***********************************************
   logic                 srst;
   logic [7:0]           wake_reg;
   logic [7:0]           cable_reg;
   logic [7:0]           regbyp_reg;
   logic [7:0]           thr_reg;
   logic [7:0]           pcfg_reg;
   logic [7:0]           lren_reg;
   logic [7:0]           sren_reg;
   logic [7:0]           pren_reg;
   logic [7:0]           pthr_reg;
   logic                 chip_reset_reg;
   logic                 link_reset_reg;
   logic                 pulse_reset_reg;
   logic                 dp_reset_reg;
   logic                 sleep_reg;
   logic                 wake_reg_o;
   logic                 err_n_reg;
   logic [7:0]           rdata_reg;
   lerc_pkg::lerc_mon_t  meta_reg;
   lerc_pkg::lerc_mon_t  sync_reg;
   logic                 lock_prev_reg;
   logic [7:0]           cnt_reg [3];
   logic [2:0]           cnt_inc;
   logic [2:0]           cnt_clr;
   logic [3:0]           stk_reg;
   logic [lerc_pkg::HOLD_W-1:0] hold_reg;
   logic                 wr_reset_sleep_control;
   logic                 rd_flg2;
   logic                 lock_rise;
   logic                 hold_done;
   logic                 wake_evt;
   logic [7:0]           thr_val;
   logic                 dec_flag;
   logic                 idle_flag;
   logic                 pkt_flag;
   logic [7:0]           flags1;
   logic [7:0]           flags2;
   logic                 err_active;
   logic [7:0]           rd_mux;

   function automatic logic [7:0] merge(input logic [7:0] old,
                                        input logic [7:0] val,
                                        input logic [7:0] msk);
      merge = (old & ~msk) | (val & msk);
   endfunction

   // Software chip reset acts as a one-cycle synchronous reset
   assign srst = !rst_n_i || chip_reset_reg; // RQ1

   assign wr_reset_sleep_control = wr_i && (addr_i == lerc_pkg::ADDR_RESET_SLEEP);
   assign rd_flg2  = rd_i && (addr_i == lerc_pkg::ADDR_SUPPLY_FLAGS);

   // ***********************************************
   // Monitor synchronisers
   // ***********************************************
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         // Idle levels, so no false remote error shows just after reset
         meta_reg      <= '{remote_err_n: 1'b1, default: 1'b0};
         sync_reg      <= '{remote_err_n: 1'b1, default: 1'b0};
         lock_prev_reg <= 1'b0;
      end else if (ce_i) begin
         meta_reg      <= mon_i;
         sync_reg      <= meta_reg;
         lock_prev_reg <= sync_reg.link_locked;
      end
   end

   assign lock_rise = sync_reg.link_locked && !lock_prev_reg;

   // ***********************************************
   // Configuration registers
   // ***********************************************
   always_ff @(posedge sys_clk_i) begin
      if (srst) begin // RQ1
         wake_reg   <= lerc_pkg::RST_WAKE;
         cable_reg  <= lerc_pkg::RST_CABLE;
         regbyp_reg <= lerc_pkg::RST_REGBYP;
         thr_reg    <= lerc_pkg::RST_THR;
         pcfg_reg   <= lerc_pkg::RST_PCFG;
         lren_reg   <= lerc_pkg::RST_LREN;
         sren_reg   <= lerc_pkg::RST_SREN;
         pren_reg   <= lerc_pkg::RST_PREN;
         pthr_reg   <= lerc_pkg::RST_PTHR;
      end else if (ce_i && wr_i) begin
         case (addr_i)
            lerc_pkg::ADDR_WAKE_CONTROL:
               wake_reg <= merge(wake_reg, wdata_i, lerc_pkg::MSK_WAKE);
            lerc_pkg::ADDR_CABLE_REFERENCE:
               cable_reg <= merge(cable_reg, wdata_i, lerc_pkg::MSK_CABLE);
            lerc_pkg::ADDR_REGULATOR_BYPASS:
               regbyp_reg <= merge(regbyp_reg, wdata_i, lerc_pkg::MSK_REGBYP);
            lerc_pkg::ADDR_ERROR_THRESHOLD:
               thr_reg <= merge(thr_reg, wdata_i, lerc_pkg::MSK_THR);
            lerc_pkg::ADDR_PACKET_COUNT_CFG:
               pcfg_reg <= merge(pcfg_reg, wdata_i, lerc_pkg::MSK_PCFG);
            lerc_pkg::ADDR_LINK_REPORT_EN:
               lren_reg <= merge(lren_reg, wdata_i, lerc_pkg::MSK_LREN);
            lerc_pkg::ADDR_SUPPLY_REPORT_EN:
               sren_reg <= merge(sren_reg, wdata_i, lerc_pkg::MSK_SREN);
            lerc_pkg::ADDR_POWER_REPORT_EN:
               pren_reg <= merge(pren_reg, wdata_i, lerc_pkg::MSK_PREN);
            lerc_pkg::ADDR_PACKET_THRESHOLD:
               pthr_reg <= wdata_i;
            default: ;
         endcase
      end
   end

   // ***********************************************
   // Resets and sleep
   // ***********************************************
   // Only the port reset resets this bit; each enabled cycle reloads it from the write, so the pulse ends
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i)
         chip_reset_reg <= 1'b0;
      else if (ce_i)
         chip_reset_reg <= wr_reset_sleep_control && wdata_i[lerc_pkg::BIT_CHIP_RESET]; // RQ1
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst) begin
         link_reset_reg  <= 1'b0;
         pulse_reset_reg <= 1'b0;
         dp_reset_reg    <= 1'b0;
      end else if (ce_i) begin
         if (wr_reset_sleep_control)
            link_reset_reg <= wdata_i[lerc_pkg::BIT_LINK_RESET]; // RQ2
         pulse_reset_reg <= wr_reset_sleep_control && wdata_i[lerc_pkg::BIT_RESET_PULSE]; // RQ3
         dp_reset_reg    <= link_reset_reg || pulse_reset_reg; // RQ2 RQ3
      end
   end

   assign wake_evt = sleep_reg &&
      ((sync_reg.local_wake && !wake_reg[lerc_pkg::BIT_LOCAL_WAKE_DIS]) || // RQ5
       (sync_reg.remote_wake && wake_reg[lerc_pkg::BIT_REMOTE_WAKE_EN])); // RQ6

   // A software write beats a wake request in the same cycle
   always_ff @(posedge sys_clk_i) begin
      if (srst) begin
         sleep_reg  <= 1'b0;
         wake_reg_o <= 1'b0;
      end else if (ce_i) begin
         wake_reg_o <= wake_evt;
         if (wr_reset_sleep_control)
            sleep_reg <= wdata_i[lerc_pkg::BIT_SLEEP]; // RQ4
         else if (wake_evt)
            sleep_reg <= 1'b0; // RQ5 RQ6
      end
   end

   // ***********************************************
   // Error hold timer
   // ***********************************************
   always_ff @(posedge sys_clk_i) begin
      if (srst)
         hold_reg <= '0;
      else if (ce_i) begin
         if (err_n_reg)
            hold_reg <= '0;
         else if (hold_reg != lerc_pkg::HOLD_CYC)
            hold_reg <= hold_reg + 1'b1;
      end
   end

   // Fires once in each assertion of the pin that lasts 25 cycles
   assign hold_done = !err_n_reg && (hold_reg == lerc_pkg::HOLD_CYC - 1'b1);

   // ***********************************************
   // Error and packet counters
   // ***********************************************
   assign cnt_inc = {evt_i.packet, evt_i.idle_err, evt_i.decode_err};

   assign cnt_clr[0] = (rd_i && addr_i == lerc_pkg::ADDR_DECODE_COUNT) || lock_rise ||
                       (hold_done && thr_reg[lerc_pkg::BIT_ERR_AUTOCLR]); // RQ23 RQ10
   assign cnt_clr[1] = (rd_i && addr_i == lerc_pkg::ADDR_IDLE_COUNT) || lock_rise ||
                       (hold_done && thr_reg[lerc_pkg::BIT_ERR_AUTOCLR]); // RQ24 RQ10
   assign cnt_clr[2] = (rd_i && addr_i == lerc_pkg::ADDR_PACKET_COUNT) ||
                       (hold_done && pcfg_reg[lerc_pkg::BIT_PKT_AUTOCLR]); // RQ11

   // An event in the clearing cycle is kept as a count of one
   always_ff @(posedge sys_clk_i) begin
      for (int i = 0; i < 3; i++) begin
         if (srst)
            cnt_reg[i] <= '0;
         else if (ce_i) begin
            if (cnt_clr[i])
               cnt_reg[i] <= {7'h00, cnt_inc[i]};
            else if (cnt_inc[i] && cnt_reg[i] != lerc_pkg::CNT_MAX)
               cnt_reg[i] <= cnt_reg[i] + 8'h01;
         end
      end
   end

   // ***********************************************
   // Flags
   // ***********************************************
   assign thr_val   = 8'h01 << thr_reg[lerc_pkg::THR_MSB:0]; // RQ12
   assign dec_flag  = cnt_reg[0] >= thr_val; // RQ14
   assign idle_flag = cnt_reg[1] >= thr_val; // RQ13
   assign pkt_flag  = cnt_reg[2] >= pthr_reg; // RQ22

   // Sticky supply and eye flags; a new event wins over the read clear
   always_ff @(posedge sys_clk_i) begin
      if (srst)
         stk_reg <= '0;
      else if (ce_i)
         stk_reg <= (stk_reg & ~{4{rd_flg2}}) |
                    {sync_reg.core_ov, sync_reg.eye_low,
                     sync_reg.dig_ov, sync_reg.io18_ov}; // RQ19 RQ20
   end

   // Link flags live, not cleared by reading them; supply flags also carry the read-cleared sticky bits
   assign flags1 = {sync_reg.refclk_unlock, 1'b0,          // RQ16 RQ26
                    !sync_reg.remote_err_n, 1'b0,          // RQ17
                    sync_reg.line_fault0 || sync_reg.line_fault1, // RQ18
                    idle_flag, 1'b0, dec_flag};
   assign flags2 = {stk_reg, sync_reg.retx_limit,
                    sync_reg.retx_event, pkt_flag, 1'b0}; // RQ21

   assign err_active = |(flags1 & lren_reg) || |(flags2 & sren_reg); // RQ15

   always_ff @(posedge sys_clk_i) begin
      if (srst)
         err_n_reg <= 1'b1;
      else if (ce_i)
         err_n_reg <= !err_active; // RQ25
   end

   // ***********************************************
   // Read port
   // ***********************************************
   always_comb begin
      rd_mux = 8'h00;
      case (addr_i)
         lerc_pkg::ADDR_WAKE_CONTROL:     rd_mux = wake_reg;
         lerc_pkg::ADDR_RESET_SLEEP:
            rd_mux = lerc_pkg::RST_RESET_SLEEP_CONTROL_RO |
                     {1'b0, link_reset_reg, pulse_reset_reg, 1'b0, sleep_reg, 3'h0};
         lerc_pkg::ADDR_CABLE_REFERENCE:  rd_mux = cable_reg;
         lerc_pkg::ADDR_REGULATOR_BYPASS: rd_mux = regbyp_reg;
         lerc_pkg::ADDR_LOCK_ERROR_STATUS:
            rd_mux = lerc_pkg::RST_STAT_RO |
                     {4'h0, sync_reg.link_locked, !err_n_reg,
                      sync_reg.clock_multiplier_lock, 1'b0}; // RQ7 RQ8 RQ9
         lerc_pkg::ADDR_ERROR_THRESHOLD:  rd_mux = thr_reg;
         lerc_pkg::ADDR_PACKET_COUNT_CFG: rd_mux = pcfg_reg;
         lerc_pkg::ADDR_LINK_REPORT_EN:   rd_mux = lren_reg;
         lerc_pkg::ADDR_LINK_FLAGS:       rd_mux = flags1;
         lerc_pkg::ADDR_SUPPLY_REPORT_EN: rd_mux = sren_reg;
         lerc_pkg::ADDR_SUPPLY_FLAGS:     rd_mux = flags2;
         lerc_pkg::ADDR_POWER_REPORT_EN:  rd_mux = pren_reg;
         lerc_pkg::ADDR_DECODE_COUNT:     rd_mux = cnt_reg[0];
         lerc_pkg::ADDR_IDLE_COUNT:       rd_mux = cnt_reg[1];
         lerc_pkg::ADDR_PACKET_COUNT:     rd_mux = cnt_reg[2];
         lerc_pkg::ADDR_PACKET_THRESHOLD: rd_mux = pthr_reg;
         default:                         rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst)
         rdata_reg <= 8'h00;
      else if (ce_i && rd_i)
         rdata_reg <= rd_mux;
   end

   assign rdata_o          = rdata_reg;
   assign error_pin_n_o    = err_n_reg;
   assign chip_reset_o     = chip_reset_reg;
   assign datapath_reset_o = dp_reset_reg;
   assign sleep_o          = sleep_reg;
   assign wake_o           = wake_reg_o;

   // ***********************************************
   // Assertions
   // ***********************************************
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_err_held;
      ce_i && !srst && hold_done && thr_reg[lerc_pkg::BIT_ERR_AUTOCLR];
   endsequence

   a_err_pin_low: assert property ( // RQ25
      ce_i && !srst && err_active |=> !error_pin_n_o)
      else $error("error pin not driven low");

   a_err_status_bit: assert property ( // RQ8
      ce_i && !srst && rd_i && addr_i == lerc_pkg::ADDR_LOCK_ERROR_STATUS
      |=> rdata_o[lerc_pkg::BIT_ERR_STATUS] == !$past(error_pin_n_o))
      else $error("error status bit disagrees with pin");

   a_chip_reset_defaults: assert property ( // RQ1
      ce_i && rst_n_i && wr_reset_sleep_control && wdata_i[lerc_pkg::BIT_CHIP_RESET]
      |=> chip_reset_o ##1 (lren_reg == lerc_pkg::RST_LREN && !chip_reset_o))
      else $error("chip reset did not restore defaults");

   a_pulse_reset_seq: assert property ( // RQ3
      ce_i && !srst && wr_reset_sleep_control && wdata_i[lerc_pkg::BIT_RESET_PULSE]
      ##1 ce_i && !srst && !wr_reset_sleep_control
      |=> datapath_reset_o && !pulse_reset_reg)
      else $error("single-shot reset not pulsed");

   a_sleep_hold_off: assert property ( // RQ4
      ce_i && !srst && !sleep_o && !wr_reset_sleep_control |=> !sleep_o)
      else $error("sleep entered without bit");

   a_remote_wake_off: assert property ( // RQ6
      ce_i && !srst && sleep_o && !wr_reset_sleep_control && !sync_reg.local_wake &&
      !wake_reg[lerc_pkg::BIT_REMOTE_WAKE_EN] |=> sleep_o)
      else $error("remote wake taken while disabled");

   a_autoclr_count: assert property ( // RQ10
      s_err_held |=> cnt_reg[0] <= 8'h01 && cnt_reg[1] <= 8'h01)
      else $error("error counters not auto-cleared");

   a_lock_clear_cnt: assert property ( // RQ23
      ce_i && !srst && lock_rise |=> cnt_reg[0] <= 8'h01)
      else $error("decode counter not cleared on lock");

   a_sticky_keep: assert property ( // RQ19
      ce_i && !srst && stk_reg[3] && !rd_flg2 |=> stk_reg[3])
      else $error("sticky flag lost without read");

endmodule // lerc_top

// ### test/lerc_remote_model.sv
// Far-side model: remote error status, monitor levels and counter events.
// Assumes the bench requests event bursts on sys_clk_i.
`timescale 1ns/1ns
module lerc_remote_model (
   // Clock, reset
   input  wire logic                sys_clk_i,
   input  wire logic                rst_n_i,
   // Requests from the bench
   input  wire lerc_pkg::lerc_mon_t levels_i,
   input  wire logic                fault_i,
   input  wire logic                go_i,
   input  wire logic [1:0]          kind_i,
   input  wire logic [7:0]          burst_i,
   input  wire logic [1:0]          gap_i,
   // Toward the block, and busy back to the bench
   output lerc_pkg::lerc_mon_t      mon_o,
   output lerc_pkg::lerc_evt_t      evt_o,
   output logic                     busy_o
);
   logic [7:0] left_reg;
   logic [1:0] tmr_reg;
   // Remote pin is low while the far side reports an error
   always_comb begin
      mon_o              = levels_i;
      mon_o.remote_err_n = ~fault_i;
   end
   assign busy_o = (left_reg != 8'h00);
   // Gap lets the far side answer promptly or slowly
   always_ff @(posedge sys_clk_i) begin
      evt_o <= '0;
      if (!rst_n_i || go_i) begin
         left_reg <= rst_n_i ? burst_i : 8'h00;
         tmr_reg  <= 2'h0;
      end else if (busy_o) begin
         if (tmr_reg == 2'h0) begin
            evt_o    <= lerc_pkg::lerc_evt_t'(3'h4 >> kind_i);
            left_reg <= left_reg - 8'h01;
            tmr_reg  <= gap_i;
         end else
            tmr_reg <= tmr_reg - 2'h1;
      end
   end
endmodule // lerc_remote_model

// ### test/test_link_error_reporting_ctrl.sv
// Self-checking bench of the link error reporting block.
// Assumes lerc_top and lerc_remote_model are compiled first.
`timescale 1ns/1ns
module test_link_error_reporting_ctrl;
   logic                sys_clk_i = 1'b0;
   logic                rst_n_i   = 1'b0;
   logic                wr_i      = 1'b0;
   logic                rd_i      = 1'b0;
   logic                go        = 1'b0;
   logic                fault     = 1'b0;
   logic                rd_seen   = 1'b0;
   logic [7:0]          addr_i    = 8'h00;
   logic [7:0]          wdata_i   = 8'h00;
   logic [7:0]          burst     = 8'h00;
   logic [1:0]          kind      = 2'h0;
   logic [1:0]          gap       = 2'h0;
   logic [7:0]          rdata_o;
   logic                busy, pin_n, chip_rst, dp_rst, sleep, wake;
   lerc_pkg::lerc_mon_t lev = '0;
   lerc_pkg::lerc_mon_t mon;
   lerc_pkg::lerc_evt_t evt;
   logic [7:0]          exp_q[$];
   logic [31:0]         seed = 32'hc7acb2d0;
   int                  n_mismatch = 0, tests_run = 0, n_chip = 0, n_dp = 0, n_wake = 0;
   localparam logic [7:0] DA [17] = '{8'h0c, 8'h10, 8'h11, 8'h12, 8'h13, 8'h18, 8'h19, 8'h1a, 8'h1b,
                                      8'h1c, 8'h1d, 8'h1e, 8'h22, 8'h24, 8'h25, 8'h30, 8'h05};
   localparam logic [7:0] DV [17] = '{8'h15, 8'h01, 8'h02, 8'h04, 8'h10, 8'ha0, 8'h00, 8'h09, 8'h00,
                                      8'h08, 8'h00, 8'hfb, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00};
   localparam logic [7:0] WA [9] = '{8'h0c, 8'h11, 8'h12, 8'h18, 8'h19, 8'h1a, 8'h1c, 8'h1e, 8'h30};
   localparam logic [7:0] WR [9] = '{8'h15, 8'h02, 8'h04, 8'ha0, 8'h00, 8'h09, 8'h08, 8'hfb, 8'hff};
   localparam logic [7:0] WM [9] = '{8'h50, 8'h41, 8'h10, 8'h0f, 8'hf8, 8'had, 8'hfe, 8'hfd, 8'hff};
   localparam logic [7:0] FL [4] = '{8'h80, 8'h20, 8'h08, 8'h08};

   lerc_top u_lerc_top (.sys_clk_i, .rst_n_i, .ce_i(1'b1), .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
      .mon_i(mon), .evt_i(evt), .error_pin_n_o(pin_n), .chip_reset_o(chip_rst),
      .datapath_reset_o(dp_rst), .sleep_o(sleep), .wake_o(wake));
   lerc_remote_model u_lerc_remote_model (.sys_clk_i, .rst_n_i, .levels_i(lev), .fault_i(fault), .go_i(go),
      .kind_i(kind), .burst_i(burst), .gap_i(gap), .mon_o(mon), .evt_o(evt), .busy_o(busy));

   always #20 sys_clk_i = ~sys_clk_i;

   // ****************
   // Tasks
   // ****************
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      if (n_mismatch == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge sys_clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge sys_clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      exp_q.push_back(e);
      @(posedge sys_clk_i);
      rd_i <= 1'b0;
   endtask
   task automatic send(input logic [1:0] k, input logic [7:0] n, input logic [1:0] g);
      int i;
      @(posedge sys_clk_i);
      go <= 1'b1;
      kind <= k;
      burst <= n;
      gap <= g;
      @(posedge sys_clk_i);
      go <= 1'b0;
      #1;
      for (i = 0; i < 1000 && busy; i++)
         @(posedge sys_clk_i);
   endtask
   task automatic defaults();
      for (int i = 0; i < 17; i++)
         rd(DA[i], DV[i]);
   endtask

   // Read data appear in the cycle after the strobe and hold until the next read
   always @(posedge sys_clk_i) begin
      if (rd_seen)
         check(rdata_o, exp_q.pop_front());
      rd_seen <= rd_i;
      n_chip += int'(chip_rst);
      n_dp += int'(dp_rst);
      n_wake += int'(wake);
   end

   initial begin
      repeat (60000) @(posedge sys_clk_i);
      n_mismatch++;
      report_and_stop();
   end

   // ****************
   // Main sequence
   // ****************
   initial begin
      logic [7:0] d;
      settle(2);
      rst_n_i <= 1'b1;
      defaults();
      for (int i = 0; i < 9; i++) begin
         d = 8'(rnd());
         wr(WA[i], d);
         rd(WA[i], (WR[i] & ~WM[i]) | (d & WM[i]));
      end
      wr(8'h10, 8'h80);
      settle(3);
      check(8'(n_chip), 8'h01);
      defaults();
      for (int k = 0; k < 8; k++) begin
         wr(8'h18, 8'(k));
         send(2'd0, 8'((1 << k) - 1), 2'(k));
         settle(6);
         rd(8'h1b, 8'h00);
         send(2'd0, 8'h01, 2'd0);
         settle(6);
         rd(8'h1b, 8'h01);
         check({7'h0, pin_n}, 8'h00);
         rd(8'h13, 8'h14);
         rd(8'h22, 8'(1 << k));
         rd(8'h1b, 8'h00);
      end
      wr(8'h1a, 8'h0d);
      wr(8'h18, 8'h01);
      send(2'd1, 8'h02, 2'd3);
      send(2'd0, 8'h05, 2'd0);
      settle(6);
      rd(8'h1b, 8'h05);
      lev.link_locked <= 1'b1;
      lev.clock_multiplier_lock <= 1'b1;
      settle(6);
      rd(8'h24, 8'h00);
      rd(8'h22, 8'h00);
      rd(8'h13, 8'h1a);
      wr(8'h1a, 8'had);
      for (int i = 0; i < 4; i++) begin
         lev.refclk_unlock <= (i == 0);
         fault <= (i == 1);
         lev.line_fault0 <= (i == 2);
         lev.line_fault1 <= (i == 3);
         settle(6);
         rd(8'h1b, FL[i]);
         check({7'h0, pin_n}, 8'h00);
      end
      wr(8'h1a, 8'h25);
      settle(4);
      check({7'h0, pin_n}, 8'h01);
      lev.line_fault1 <= 1'b0;
      lev.core_ov <= 1'b1;
      lev.eye_low <= 1'b1;
      lev.dig_ov <= 1'b1;
      lev.io18_ov <= 1'b1;
      lev.retx_limit <= 1'b1;
      lev.retx_event <= 1'b1;
      settle(4);
      lev[9:6] <= 4'h0;
      settle(4);
      rd(8'h1d, 8'hfc);
      rd(8'h1d, 8'h0c);
      wr(8'h30, 8'h03);
      send(2'd2, 8'h03, 2'd1);
      settle(6);
      rd(8'h1d, 8'h0e);
      rd(8'h25, 8'h03);
      rd(8'h1d, 8'h0c);
      lev.retx_limit <= 1'b0;
      lev.retx_event <= 1'b0;
      wr(8'h19, 8'h08);
      wr(8'h18, 8'h08);
      wr(8'h1c, 8'h02);
      send(2'd2, 8'h03, 2'd0);
      send(2'd0, 8'h02, 2'd0);
      settle(40);
      rd(8'h25, 8'h00);
      rd(8'h22, 8'h00);
      check({7'h0, pin_n}, 8'h01);
      wr(8'h10, 8'h40);
      settle(3);
      check({7'h0, dp_rst}, 8'h01);
      rd(8'h10, 8'h41);
      wr(8'h10, 8'h00);
      settle(3);
      n_dp = 0;
      wr(8'h10, 8'h20);
      settle(4);
      check(8'(n_dp), 8'h01);
      rd(8'h10, 8'h01);
      wr(8'h0c, 8'h50);
      wr(8'h10, 8'h08);
      settle(2);
      check({7'h0, sleep}, 8'h01);
      lev.local_wake <= 1'b1;
      settle(6);
      check({7'h0, sleep}, 8'h01);
      n_wake = 0;
      wr(8'h0c, 8'h10);
      settle(3);
      check({7'h0, sleep}, 8'h00);
      check(8'(n_wake), 8'h01);
      lev.local_wake <= 1'b0;
      wr(8'h0c, 8'h00);
      wr(8'h10, 8'h08);
      lev.remote_wake <= 1'b1;
      settle(6);
      check({7'h0, sleep}, 8'h01);
      n_wake = 0;
      wr(8'h0c, 8'h10);
      settle(3);
      check({7'h0, sleep}, 8'h00);
      check(8'(n_wake), 8'h01);
      settle(2);
      report_and_stop();
   end
endmodule // test_link_error_reporting_ctrl
